// ===== verilog/rcc_defs.vh
// Register map, field positions, reset values and encodings of the reset cause block.
`ifndef RCC_DEFS_VH
`define RCC_DEFS_VH

`define RCC_ADDR_W 12
`define RCC_OFS_CTRL 12'h000
`define RCC_OFS_INT_STATUS 12'h004
`define RCC_OFS_INT_MASK 12'h008
`define RCC_OFS_INT_PRIO 12'h00c
`define RCC_OFS_LAST_CAUSE 12'h010

`define RCC_BIT_PRIO_EN 7
`define RCC_BIT_SW_BOR_EN 6
`define RCC_BIT_CFG_MISMATCH 5
`define RCC_BIT_RESET_INSTR 4
`define RCC_BIT_WDT_TIMEOUT 3
`define RCC_BIT_POWERDOWN 2
`define RCC_BIT_POWER_ON 1
`define RCC_BIT_BROWN_OUT 0
`define RCC_CTRL_RESET 8'h7c
`define RCC_CTRL_WR_MASK 8'hf3

`define RCC_BOR_CFG_SOFTWARE 2'h1
`define RCC_BOR_CFG_OFF 2'h0

`define RCC_EV_W 6
`define RCC_EV_POWER_ON 0
`define RCC_EV_BROWN_OUT 1
`define RCC_EV_WDT_TIMEOUT 2
`define RCC_EV_CFG_MISMATCH 3
`define RCC_EV_RESET_INSTR 4
`define RCC_EV_SLEEP 5

`define RCC_CAUSE_NONE 3'h0
`define RCC_CAUSE_POWER_ON 3'h1
`define RCC_CAUSE_BROWN_OUT 3'h2
`define RCC_CAUSE_WDT 3'h3
`define RCC_CAUSE_CFG_MISMATCH 3'h4
`define RCC_CAUSE_RESET_INSTR 3'h5

`endif

// ===== verilog/apb_slave_port.v
// APB3 slave handshake: phase decode, zero wait answer, error on unmapped access.
`timescale 1ns/1ps
module apb_slave_port (
  // Bus side
  input wire psel,
  input wire penable,
  input wire pwrite,
  output wire pready,
  output wire pslverr,
  // Register side
  input wire addrHit,
  output wire setupRead,
  output wire writeStb
);
  wire accessPhase;

  // Every access ends in its first access cycle, so no wait state is ever inserted.
  assign accessPhase = psel & penable;
  assign pready = 1'b1;
  assign pslverr = accessPhase & ~addrHit;
  assign setupRead = psel & ~penable & ~pwrite;
  assign writeStb = accessPhase & pwrite & addrHit;
endmodule

// ===== verilog/sticky_w1c_bank.v
// Bank of sticky event bits, cleared by writing ones, with a set that beats the clear.
`timescale 1ns/1ps
module sticky_w1c_bank #(
  parameter WIDTH = 6
) (
  // Clock and reset
  input wire mclk,
  input wire rst_b,
  // Events and software clear
  input wire [WIDTH-1:0] eventIn,
  input wire clearStb,
  input wire [WIDTH-1:0] clearBits,
  // State
  output wire [WIDTH-1:0] status
);
  reg [WIDTH-1:0] status_q;
  wire [WIDTH-1:0] status_d;

  // An event landing in the clear cycle stays recorded.
  assign status_d = (status_q & ~(clearStb ? clearBits : {WIDTH{1'b0}})) | eventIn;

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      status_q <= {WIDTH{1'b0}};
    end else begin
      status_q <= status_d;
    end
  end

  assign status = status_q;
endmodule

// ===== verilog/reset_cause_ctrl.v
// Reset cause and control register with event interrupts and a two level priority resolver.
`timescale 1ns/1ps
`include "rcc_defs.vh"

// Functional notes
// - With the priority enable bit (bit 7) set, requests are split into high and low levels; clear, all go to one level.
// - With the brown-out configuration field at 01, the software brown-out enable bit turns brown-out detection on or off.
// - With the configuration field at 00, 10 or 11 the software enable bit has no effect and reads as zero.
// - A configuration mismatch reset clears bit 5, and only a software write sets it again.
// - A reset caused by the reset instruction clears bit 4, and only firmware sets it again.
// - Bit 3 is set by power-up, the watchdog clear and the sleep instruction, and cleared by a watchdog time-out.
// - Bit 2 is set by power-up or the watchdog clear instruction, and cleared by the sleep instruction.
// - A power-on reset clears bit 1, and only a firmware write sets it again.
// - A brown-out reset clears bit 0, and only a firmware write sets it again.
// - Bits 3 and 2 are read-only resetting to 1; bits 7, 1, 0 reset to 0 and bits 6, 5, 4 to 1, all writable.
module reset_cause_ctrl #(
  parameter NUM_SRC = 8
) (
  // Clock and power-on reset
  input wire mclk,
  input wire rst_b,
  // APB register bus
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`RCC_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Reset sources and core instructions, one cycle pulses
  input wire powerOnEvent,
  input wire brownOutEvent,
  input wire wdtTimeoutEvent,
  input wire cfgMismatchEvent,
  input wire resetInstrEvent,
  input wire sleepInstr,
  input wire watchdogClearInstr,
  // Configuration field
  input wire [1:0] brownoutConfigField,
  // Peripheral interrupt requests
  input wire [NUM_SRC-1:0] intReq,
  // Block outputs
  output wire brownoutDetectEnable,
  output wire interruptPriorityEnable,
  output wire intHighReq,
  output wire intLowReq,
  output wire irq
);
  reg [7:0] resetCauseControl_q;
  reg [7:0] resetCauseControl_d;
  reg [`RCC_EV_W-1:0] intMask_q;
  reg [NUM_SRC-1:0] intPrio_q;
  reg [2:0] lastCause_q;
  reg [2:0] lastCause_d;
  reg [31:0] prdata_q;
  reg [31:0] readMux;
  reg intHighReq_q;
  reg intLowReq_q;
  reg irq_q;
  reg bodEnable_q;
  reg addrHit;
  wire setupRead;
  wire writeStb;
  wire [`RCC_EV_W-1:0] eventVec;
  wire [`RCC_EV_W-1:0] intStatus;
  wire swBorActive;
  wire wrCtrl;
  wire wrStatus;
  wire wrMask;
  wire wrPrio;
  wire [7:0] ctrlReadValue;
  wire [7:0] wrByte;

  function regHit;
    input [`RCC_ADDR_W-1:0] addr;
    input [`RCC_ADDR_W-1:0] offset;
    begin
      regHit = (addr == offset);
    end
  endfunction

  // Bus handshake and register decode.
  apb_slave_port u_apb (
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .pready(pready),
    .pslverr(pslverr),
    .addrHit(addrHit),
    .setupRead(setupRead),
    .writeStb(writeStb)
  );

  always @* begin
    addrHit = regHit(paddr, `RCC_OFS_CTRL) |
              regHit(paddr, `RCC_OFS_INT_STATUS) |
              regHit(paddr, `RCC_OFS_INT_MASK) |
              regHit(paddr, `RCC_OFS_INT_PRIO) |
              regHit(paddr, `RCC_OFS_LAST_CAUSE);
  end

  assign wrCtrl = writeStb & regHit(paddr, `RCC_OFS_CTRL);
  assign wrStatus = writeStb & regHit(paddr, `RCC_OFS_INT_STATUS);
  assign wrMask = writeStb & regHit(paddr, `RCC_OFS_INT_MASK);
  assign wrPrio = writeStb & regHit(paddr, `RCC_OFS_INT_PRIO);
  assign wrByte = pwdata[7:0];

  // Software enable only counts when the configuration hands control to software.
  assign swBorActive = (brownoutConfigField == `RCC_BOR_CFG_SOFTWARE);

  // Reset cause and control register.
  always @* begin
    resetCauseControl_d = resetCauseControl_q;
    if (wrCtrl) begin
      // Bits 3 and 2 ignore the write; hardware alone moves them.
      resetCauseControl_d = (resetCauseControl_q & ~`RCC_CTRL_WR_MASK) |
                            (wrByte & `RCC_CTRL_WR_MASK);
    end
    // Hardware events follow the write so that a reset cause is never lost to software.
    if (cfgMismatchEvent) begin
      resetCauseControl_d[`RCC_BIT_CFG_MISMATCH] = 1'b0;
    end
    if (resetInstrEvent) begin
      resetCauseControl_d[`RCC_BIT_RESET_INSTR] = 1'b0;
    end
    if (powerOnEvent || watchdogClearInstr || sleepInstr) begin
      resetCauseControl_d[`RCC_BIT_WDT_TIMEOUT] = 1'b1;
    end
    if (wdtTimeoutEvent) begin
      // A time-out is the rarer and more telling event, so it beats a same-cycle set.
      resetCauseControl_d[`RCC_BIT_WDT_TIMEOUT] = 1'b0;
    end
    if (powerOnEvent || watchdogClearInstr) begin
      resetCauseControl_d[`RCC_BIT_POWERDOWN] = 1'b1;
    end
    if (sleepInstr) begin
      resetCauseControl_d[`RCC_BIT_POWERDOWN] = 1'b0;
    end
    if (powerOnEvent) begin
      resetCauseControl_d[`RCC_BIT_POWER_ON] = 1'b0;
    end
    if (brownOutEvent) begin
      resetCauseControl_d[`RCC_BIT_BROWN_OUT] = 1'b0;
    end
  end

  // The register is only reset by the power-on reset; other causes leave unrelated flags alone.
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      resetCauseControl_q <= `RCC_CTRL_RESET;
    end else begin
      resetCauseControl_q <= resetCauseControl_d;
    end
  end

  // Software enable reads as zero whenever it has no effect.
  assign ctrlReadValue = {resetCauseControl_q[`RCC_BIT_PRIO_EN],
                          resetCauseControl_q[`RCC_BIT_SW_BOR_EN] & swBorActive,
                          resetCauseControl_q[5:0]};

  // Brown-out detection enable.
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      bodEnable_q <= 1'b0;
    end else if (swBorActive) begin
      bodEnable_q <= resetCauseControl_q[`RCC_BIT_SW_BOR_EN];
    end else begin
      // Field 00 turns detection off; 10 and 11 leave it under hardware control.
      bodEnable_q <= (brownoutConfigField != `RCC_BOR_CFG_OFF);
    end
  end

  assign brownoutDetectEnable = bodEnable_q;
  assign interruptPriorityEnable = resetCauseControl_q[`RCC_BIT_PRIO_EN];

  // Last reset cause, highest ranking cause first when several coincide.
  always @* begin
    lastCause_d = lastCause_q;
    if (powerOnEvent) begin
      lastCause_d = `RCC_CAUSE_POWER_ON;
    end else if (brownOutEvent) begin
      lastCause_d = `RCC_CAUSE_BROWN_OUT;
    end else if (wdtTimeoutEvent) begin
      lastCause_d = `RCC_CAUSE_WDT;
    end else if (cfgMismatchEvent) begin
      lastCause_d = `RCC_CAUSE_CFG_MISMATCH;
    end else if (resetInstrEvent) begin
      lastCause_d = `RCC_CAUSE_RESET_INSTR;
    end
  end

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      lastCause_q <= `RCC_CAUSE_NONE;
    end else begin
      lastCause_q <= lastCause_d;
    end
  end

  // Sticky event status for the interrupt output.
  assign eventVec = {sleepInstr, resetInstrEvent, cfgMismatchEvent,
                     wdtTimeoutEvent, brownOutEvent, powerOnEvent};

  sticky_w1c_bank #(
    .WIDTH(`RCC_EV_W)
  ) u_status (
    .mclk(mclk),
    .rst_b(rst_b),
    .eventIn(eventVec),
    .clearStb(wrStatus),
    .clearBits(pwdata[`RCC_EV_W-1:0]),
    .status(intStatus)
  );

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      intMask_q <= {`RCC_EV_W{1'b0}};
    end else if (wrMask) begin
      intMask_q <= pwdata[`RCC_EV_W-1:0];
    end
  end

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(intStatus & intMask_q);
    end
  end

  assign irq = irq_q;

  // Per source priority: one marks a high priority source.
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      intPrio_q <= {NUM_SRC{1'b0}};
    end else if (wrPrio) begin
      intPrio_q <= pwdata[NUM_SRC-1:0];
    end
  end

  // Compatibility mode routes every request to the high level and keeps the low level quiet.
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      intHighReq_q <= 1'b0;
      intLowReq_q <= 1'b0;
    end else if (resetCauseControl_q[`RCC_BIT_PRIO_EN]) begin
      intHighReq_q <= |(intReq & intPrio_q);
      intLowReq_q <= |(intReq & ~intPrio_q);
    end else begin
      intHighReq_q <= |intReq;
      intLowReq_q <= 1'b0;
    end
  end

  assign intHighReq = intHighReq_q;
  assign intLowReq = intLowReq_q;

  // Read data is captured in the setup cycle and held through the access cycle.
  always @* begin
    readMux = 32'h0000_0000;
    if (regHit(paddr, `RCC_OFS_CTRL)) begin
      readMux[7:0] = ctrlReadValue;
    end else if (regHit(paddr, `RCC_OFS_INT_STATUS)) begin
      readMux[`RCC_EV_W-1:0] = intStatus;
    end else if (regHit(paddr, `RCC_OFS_INT_MASK)) begin
      readMux[`RCC_EV_W-1:0] = intMask_q;
    end else if (regHit(paddr, `RCC_OFS_INT_PRIO)) begin
      readMux[NUM_SRC-1:0] = intPrio_q;
    end else if (regHit(paddr, `RCC_OFS_LAST_CAUSE)) begin
      readMux[2:0] = lastCause_q;
    end
  end

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      prdata_q <= 32'h0000_0000;
    end else if (setupRead) begin
      prdata_q <= readMux;
    end
  end

  assign prdata = prdata_q;
endmodule

// ===== tb/reset_cause_chk.sv
// Port checker for the reset cause block.
`timescale 1ns/1ps
module reset_cause_chk #(
  parameter NUM_SRC = 8
) (
  // Clock and reset
  input wire mclk,
  input wire rst_b,
  // Register bus
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Control and requests
  input wire [1:0] brownoutConfigField,
  input wire [NUM_SRC-1:0] intReq,
  input wire brownoutDetectEnable,
  input wire interruptPriorityEnable,
  input wire intHighReq,
  input wire intLowReq
);
  wire acc = psel && penable;
  wire rd = acc && !pwrite;
  wire mapped = (paddr == 12'h000) || (paddr == 12'h004) || (paddr == 12'h008) ||
                (paddr == 12'h00c) || (paddr == 12'h010);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  chk_ready_on: assert property (acc |-> pready)
    else $error("ready missing");
  chk_err_flag: assert property (acc |-> pslverr == !mapped)
    else $error("error flag wrong");
  chk_unmapped_zero: assert property (rd && !mapped |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  chk_ctrl_upper: assert property (rd && paddr == 12'h0 |-> prdata[31:8] == 24'h0)
    else $error("upper bits set");
  chk_sw_hidden: assert property (rd && paddr == 12'h0 && $past(brownoutConfigField) != 2'h1
    |-> !prdata[6])
    else $error("enable bit visible");
  chk_bor_off: assert property ($past(rst_b) && $past(brownoutConfigField) == 2'h0
    |-> !brownoutDetectEnable)
    else $error("detection not off");
  chk_bor_hw: assert property ($past(rst_b) && $past(brownoutConfigField[1])
    |-> brownoutDetectEnable)
    else $error("detection not on");
  chk_low_prio: assert property (intLowReq |-> $past(interruptPriorityEnable))
    else $error("low level without priority");
  chk_single_level: assert property ($past(rst_b) && !$past(interruptPriorityEnable)
    |-> intHighReq == $past(|intReq) && !intLowReq)
    else $error("single level routing wrong");
endmodule

bind reset_cause_ctrl reset_cause_chk #(.NUM_SRC(NUM_SRC)) chk_u (.mclk(mclk),
  .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .brownoutConfigField(brownoutConfigField), .intReq(intReq),
  .brownoutDetectEnable(brownoutDetectEnable),
  .interruptPriorityEnable(interruptPriorityEnable), .intHighReq(intHighReq),
  .intLowReq(intLowReq));

// ===== tb/tb_top.sv
// Self-checking bench for the reset cause block.
`timescale 1ns/1ps
module tb_top;
  reg mclk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
  reg [11:0] paddr = 0;
  reg [31:0] pwdata = 0, lfsr = 32'h6d8c;
  reg [6:0] ev = 0;
  reg [1:0] cfg = 2'h1;
  reg [7:0] req = 0;
  reg [47:0] clrTab = 48'h04_10_20_08_01_02;
  wire [31:0] prdata;
  wire pready, pslverr, detEn, prioEn, hiReq, loReq, irq;
  integer miscompares = 0, cmp_count = 0, i;
  reg [32:0] q[$];
  reset_cause_ctrl #(.NUM_SRC(8)) dut_u (.mclk(mclk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .powerOnEvent(ev[0]),
    .brownOutEvent(ev[1]), .wdtTimeoutEvent(ev[2]), .cfgMismatchEvent(ev[3]),
    .resetInstrEvent(ev[4]), .sleepInstr(ev[5]), .watchdogClearInstr(ev[6]),
    .brownoutConfigField(cfg), .intReq(req), .brownoutDetectEnable(detEn),
    .interruptPriorityEnable(prioEn), .intHighReq(hiReq), .intLowReq(loReq), .irq(irq));
  initial begin
    forever #2.5 mclk = ~mclk;
  end
  function [31:0] nxt(input [31:0] s);
    nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task chk(input [32:0] exp, input [32:0] got);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // Reads note {error, data} for the watcher; the request holds until ready.
  task bus(input w, input [11:0] a, input [31:0] d, input [32:0] exp);
    begin
      @(posedge mclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      if (!w) q.push_back(exp);
      @(posedge mclk);
      penable <= 1;
      @(posedge mclk);
      while (pready !== 1'b1) @(posedge mclk);
      psel <= 0;
      penable <= 0;
    end
  endtask
  task pulse(input [6:0] e);
    begin
      @(posedge mclk);
      ev <= e;
      @(posedge mclk);
      ev <= 0;
    end
  endtask
  always @(posedge mclk) begin
    if (psel && penable && pready && !pwrite) chk(q.pop_front(), {pslverr, prdata});
  end
  task close_out;
    begin
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  initial begin
    #20000;
    miscompares = miscompares + 1;
    close_out;
  end
  initial begin
    repeat (12) @(posedge mclk);
    rst_b <= 1;
    bus(0, 0, 0, 33'h7c);
    bus(1, 0, 0, 0);
    bus(0, 0, 0, 33'h0c);
    bus(1, 0, 32'hff, 0);
    bus(0, 0, 0, 33'hff);
    bus(0, 12'h020, 0, 33'h100000000);
    $display("register test done");
    // Each cause alone must touch only its own flag.
    for (i = 0; i < 6; i = i + 1) begin
      bus(1, 0, 32'hff, 0);
      pulse(7'h1 << i);
      bus(0, 0, 0, {25'h0, 8'hff ^ clrTab[8*i +: 8]});
      pulse(7'h40);
    end
    bus(0, 0, 0, 33'hff);
    bus(0, 12'h010, 0, 33'h5);
    $display("event test done");
    bus(0, 12'h004, 0, 33'h3f);
    chk(0, irq);
    bus(1, 12'h008, 32'h2, 0);
    bus(0, 12'h008, 0, 33'h2);
    repeat (2) @(negedge mclk);
    chk(1, irq);
    bus(1, 12'h004, 32'h3f, 0);
    repeat (2) @(negedge mclk);
    chk(0, irq);
    bus(0, 12'h004, 0, 33'h0);
    $display("interrupt test done");
    for (i = 0; i < 4; i = i + 1) begin
      cfg <= i[1:0];
      bus(0, 0, 0, {25'h0, 1'b1, i == 1, 6'h3f});
      chk(i != 0, detEn);
    end
    cfg <= 2'h1;
    bus(1, 0, 32'hbf, 0);
    bus(0, 0, 0, 33'hbf);
    repeat (2) @(negedge mclk);
    chk(0, detEn);
    $display("config test done");
    for (i = 0; i < 8; i = i + 1) begin
      lfsr = nxt(lfsr);
      bus(1, 12'h00c, lfsr[15:8], 0);
      bus(0, 12'h00c, 0, {25'h0, lfsr[15:8]});
      bus(1, 0, {i[0], 7'h7f}, 0);
      req <= lfsr[7:0];
      repeat (2) @(negedge mclk);
      chk(i[0] ? {|(req & lfsr[15:8]), |(req & ~lfsr[15:8])} : {|req, 1'b0}, {hiReq, loReq});
      chk(i[0], prioEn);
    end
    $display("priority test done");
    @(posedge mclk);
    rst_b <= 0;
    @(posedge mclk);
    rst_b <= 1;
    bus(0, 0, 0, 33'h7c);
    bus(0, 12'h010, 0, 33'h0);
    @(posedge mclk);
    close_out;
  end
endmodule
